// ### logic/ipx_core.sv
`timescale 1ns/1ps
`default_nettype none
module ipx_core #(
	parameter int PORT_W = 8
) (
	input  wire logic              core_clk_in,
	input  wire logic              nrst_in,
	input  wire ipx_pkg::ipx_sfr_s sfr_in,
	output logic [7:0]             sfr_rdata_out,
	input  wire logic [3:0]        ext_pins_in,
	input  wire logic [PORT_W-1:0] port5_in,
	input  wire logic [PORT_W-1:0] port6_in,
	input  wire logic [PORT_W-1:0] port9_in,
	input  wire logic              tmr0_ovf_in,
	input  wire logic              tmr1_ovf_in,
	input  wire logic [9:0]        periph_flags_in,
	input  wire logic [15:0]       src_enable_in,
	input  wire logic              global_irq_enable_in,
	input  wire logic              irq_ack_in,
	input  wire logic              reti_in,
	output ipx_pkg::ipx_req_s      irq_out,
	output logic                   timer_zero_run_out,
	output logic                   timer_one_run_out,
	output logic                   wake_out
);
	import ipx_pkg::*;

	typedef struct packed {
		logic [7:0]          tctl;
		logic [7:0]          pchg;
		logic [7:0]          x23f;
		logic [7:0]          xen;
		logic [7:0]          edg1;
		logic [7:0]          edg2;
		logic [7:0]          pri0;
		logic [7:0]          pri1;
		logic [7:0]          pri2;
		logic [7:0]          pri3;
		logic [3:0]          filt;
		logic [3:0]          filt_old;
		logic [3:0][6:0]     dg_cnt;
		logic [PORT_W-1:0]   p5_old;
		logic [PORT_W-1:0]   p6_old;
		logic [PORT_W-1:0]   p9_old;
		ipx_svc_e            svc;
		ipx_req_s            irq;
		logic                wake;
		logic [7:0]          rdata;
	} ipx_state_s;

	ipx_state_s st_q;
	ipx_state_s st_d;

	// ------------------------------------------------------------
	// Combinational helpers
	// ------------------------------------------------------------
	logic [6:0]  dg_lim;
	logic [3:0]  rise;
	logic [3:0]  fall;
	logic [3:0]  ev;
	logic        set_e0;
	logic        set_e1;
	logic        set_e2;
	logic        set_e3;
	logic        set_p5;
	logic        set_p6;
	logic        set_p9;
	logic [15:0] flags;
	logic [15:0] prio;
	logic [15:0] pend;
	logic [15:0] hi_p;
	logic [15:0] lo_p;
	logic        ack_e0;
	logic        ack_e1;
	logic        ack_t0;
	logic        ack_t1;
	logic [7:0]  wmask;

	// ------------------------------------------------------------
	// Deglitch and event decode
	// ------------------------------------------------------------
	// Spans are counted in core cycles, so they only hold at the nominal clock
	// Filter length from the two deglitch select bits
	always_comb begin
		case (st_q.edg1[ED_DG_LO+1 -: 2])
			2'b00:   dg_lim = 7'(DG0_CYC);
			2'b01:   dg_lim = 7'(DG1_CYC);
			default: dg_lim = 7'(DG2_CYC);
		endcase
	end

	// Edge and level decode on filtered pins; pin change decode on raw port inputs
	always_comb begin
		rise   = st_q.filt & ~st_q.filt_old;
		fall   = ~st_q.filt & st_q.filt_old;
		set_e0 = st_q.tctl[TC_ZERO_TYPE]
			? (st_q.edg1[ED_ZERO_SEL] ? rise[0] : fall[0])
			: ~st_q.filt[0];
		set_e1 = st_q.tctl[TC_ONE_TYPE]
			? (st_q.edg1[ED_ONE_SEL] ? rise[1] : fall[1])
			: ~st_q.filt[1];
		set_e2 = st_q.xen[0] & (st_q.edg2[0] ? rise[2] : fall[2]);
		set_e3 = st_q.xen[1] & (st_q.edg2[1] ? rise[3] : fall[3]);
		ev     = {set_e3, set_e2, set_e1, set_e0};
		// Any pin of an enabled port counts; disabled ports are ignored
		set_p5 = st_q.pchg[PC_EN5] & (|(port5_in ^ st_q.p5_old));
		set_p6 = st_q.pchg[PC_EN6] & (|(port6_in ^ st_q.p6_old));
		set_p9 = st_q.pchg[PC_EN9] & (|(port9_in ^ st_q.p9_old));
	end

	// ------------------------------------------------------------
	// Arbitration inputs
	// ------------------------------------------------------------
	// Source flag and priority vectors, in arbitration order
	// The flag port stops at ten bits, so sources 14 and 15 never request
	always_comb begin
		flags       = 16'h0000;
		flags[0]    = st_q.tctl[TC_ZERO_FLAG];
		flags[1]    = st_q.tctl[TC_ZERO_OVF];
		flags[2]    = st_q.tctl[TC_ONE_FLAG];
		flags[3]    = st_q.tctl[TC_ONE_OVF];
		flags[4]    = periph_flags_in[0];
		flags[5]    = st_q.pchg[PC_FLAG5] | st_q.pchg[PC_FLAG6] | st_q.pchg[PC_FLAG9];
		flags[6]    = |periph_flags_in[3:1];
		flags[7]    = st_q.x23f[0] | st_q.x23f[1];
		flags[13:8] = periph_flags_in[9:4];
		prio = {st_q.pri3[5], st_q.pri3[1], st_q.pri3[0],
			st_q.pri2[5], st_q.pri2[2], st_q.pri2[0],
			st_q.pri1[7], st_q.pri1[4], st_q.pri1[3], st_q.pri1[1],
			st_q.pri0[6], st_q.pri0[4], st_q.pri0[3], st_q.pri0[2],
			st_q.pri0[1], st_q.pri0[0]};
		// Level-held flags re-request after return with no extra state
		pend = flags & src_enable_in & {NSRC{global_irq_enable_in}};
		hi_p = pend & prio;
		lo_p = pend & ~prio;
	end

	// ------------------------------------------------------------
	// Vector acknowledge
	// ------------------------------------------------------------
	// Vector acknowledge clears only the self-clearing flags
	always_comb begin
		ack_e0 = irq_ack_in & st_q.irq.req & (st_q.irq.src == SRC_EXT0);
		ack_t0 = irq_ack_in & st_q.irq.req & (st_q.irq.src == SRC_TMR0);
		ack_e1 = irq_ack_in & st_q.irq.req & (st_q.irq.src == SRC_EXT1);
		ack_t1 = irq_ack_in & st_q.irq.req & (st_q.irq.src == SRC_TMR1);
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_d  = st_q;
		wmask = 8'h00;
		// Deglitch: unless bypassed, output follows only after a stable run of samples
		for (int i = 0; i < 4; i++) begin
			if (st_q.edg1[ED_DG_LO+1 -: 2] == DG_BYPASS) begin
				st_d.filt[i]   = ext_pins_in[i];
				st_d.dg_cnt[i] = 7'h00;
			end else if (ext_pins_in[i] == st_q.filt[i]) begin
				st_d.dg_cnt[i] = 7'h00;
			end else if (st_q.dg_cnt[i] + 7'h01 >= dg_lim) begin
				st_d.filt[i]   = ext_pins_in[i];
				st_d.dg_cnt[i] = 7'h00;
			end else begin
				st_d.dg_cnt[i] = st_q.dg_cnt[i] + 7'h01;
			end
		end
		st_d.filt_old = st_q.filt;
		st_d.p5_old   = port5_in;
		st_d.p6_old   = port6_in;
		st_d.p9_old   = port9_in;

		// Software writes; reserved bits stay zero
		if (sfr_in.wr) begin
			if (sfr_in.addr == ADDR_TCTL) begin
				st_d.tctl = sfr_in.wdata & MASK_TCTL;
			end else if (sfr_in.addr == ADDR_PCHG) begin
				st_d.pchg = sfr_in.wdata & MASK_PCHG;
			end else if (sfr_in.addr == ADDR_X23F) begin
				st_d.x23f = sfr_in.wdata & MASK_X23F;
			end else if (sfr_in.addr == ADDR_XEN) begin
				st_d.xen  = sfr_in.wdata & MASK_XEN;
			end else if (sfr_in.addr == ADDR_EDG1) begin
				st_d.edg1 = sfr_in.wdata & MASK_EDG1;
			end else if (sfr_in.addr == ADDR_EDG2) begin
				st_d.edg2 = sfr_in.wdata & MASK_EDG2;
			end else if (sfr_in.addr == ADDR_PRI0) begin
				st_d.pri0 = sfr_in.wdata & MASK_PRI0;
			end else if (sfr_in.addr == ADDR_PRI1) begin
				st_d.pri1 = sfr_in.wdata & MASK_PRI1;
			end else if (sfr_in.addr == ADDR_PRI2) begin
				st_d.pri2 = sfr_in.wdata & MASK_PRI2;
			end else if (sfr_in.addr == ADDR_PRI3) begin
				st_d.pri3 = sfr_in.wdata & MASK_PRI3;
			end
		end

		// Hardware clear on vector, then hardware set; set wins over both
		if (ack_e0) st_d.tctl[TC_ZERO_FLAG] = 1'b0;
		if (ack_e1) st_d.tctl[TC_ONE_FLAG]  = 1'b0;
		if (ack_t0) st_d.tctl[TC_ZERO_OVF]  = 1'b0;
		if (ack_t1) st_d.tctl[TC_ONE_OVF]   = 1'b0;
		wmask[TC_ZERO_FLAG] = set_e0;
		wmask[TC_ONE_FLAG]  = set_e1;
		wmask[TC_ZERO_OVF]  = tmr0_ovf_in;
		wmask[TC_ONE_OVF]   = tmr1_ovf_in;
		st_d.tctl = st_d.tctl | wmask;
		st_d.x23f = st_d.x23f | {6'h00, set_e3, set_e2};
		st_d.pchg[PC_FLAG5] = st_d.pchg[PC_FLAG5] | set_p5;
		st_d.pchg[PC_FLAG6] = st_d.pchg[PC_FLAG6] | set_p6;
		st_d.pchg[PC_FLAG9] = st_d.pchg[PC_FLAG9] | set_p9;

		// Wake is a registered one-cycle pulse per edge or pin change, held high while a level-mode pin is low
		st_d.wake = (|ev) | set_p5 | set_p6 | set_p9;

		// Service level tracking: a taken request raises the level
		if (irq_ack_in && st_q.irq.req) begin
			if (st_q.irq.high) begin
				st_d.svc = (st_q.svc == SVC_LOW) ? SVC_BOTH : SVC_HIGH;
			end else begin
				st_d.svc = SVC_LOW;
			end
		end else if (reti_in) begin
			case (st_q.svc)
				SVC_BOTH: st_d.svc = SVC_LOW;
				default:  st_d.svc = SVC_IDLE;
			endcase
		end

		// Arbitration: high may preempt low, low waits for idle
		st_d.irq.req  = 1'b0;
		st_d.irq.src  = 4'h0;
		st_d.irq.high = 1'b0;
		if (!(irq_ack_in && st_q.irq.req)) begin
			if ((st_q.svc == SVC_IDLE || st_q.svc == SVC_LOW) && |hi_p) begin
				st_d.irq.req  = 1'b1;
				st_d.irq.high = 1'b1;
				for (int i = NSRC - 1; i >= 0; i--) begin
					if (hi_p[i]) st_d.irq.src = 4'(i);
				end
			end else if (st_q.svc == SVC_IDLE && |lo_p) begin
				st_d.irq.req = 1'b1;
				for (int i = NSRC - 1; i >= 0; i--) begin
					if (lo_p[i]) st_d.irq.src = 4'(i);
				end
			end
		end

		// Read data, one cycle after the address; unmapped reads zero
		// Reads have no side effect, so polling never loses a flag
		if (sfr_in.addr == ADDR_TCTL) begin
			st_d.rdata = st_q.tctl;
		end else if (sfr_in.addr == ADDR_PCHG) begin
			st_d.rdata = st_q.pchg;
		end else if (sfr_in.addr == ADDR_X23F) begin
			st_d.rdata = st_q.x23f;
		end else if (sfr_in.addr == ADDR_XEN) begin
			st_d.rdata = st_q.xen;
		end else if (sfr_in.addr == ADDR_EDG1) begin
			st_d.rdata = st_q.edg1;
		end else if (sfr_in.addr == ADDR_EDG2) begin
			st_d.rdata = st_q.edg2;
		end else if (sfr_in.addr == ADDR_PRI0) begin
			st_d.rdata = st_q.pri0;
		end else if (sfr_in.addr == ADDR_PRI1) begin
			st_d.rdata = st_q.pri1;
		end else if (sfr_in.addr == ADDR_PRI2) begin
			st_d.rdata = st_q.pri2;
		end else if (sfr_in.addr == ADDR_PRI3) begin
			st_d.rdata = st_q.pri3;
		end else begin
			st_d.rdata = 8'h00;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			// Constants only; every flag and request starts clear
			st_q      <= '0;
			st_q.filt <= 4'hf;   // Idle-high pins, avoids a false fall at start
			st_q.filt_old <= 4'hf;
			st_q.svc  <= SVC_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// Output ports
	// ------------------------------------------------------------
	// Outputs straight from the state register
	assign sfr_rdata_out      = st_q.rdata;
	assign irq_out            = st_q.irq;
	assign timer_zero_run_out = st_q.tctl[TC_ZERO_RUN];
	assign timer_one_run_out  = st_q.tctl[TC_ONE_RUN];
	assign wake_out           = st_q.wake;
endmodule
`default_nettype wire

// ### shared/ipx_pkg.sv
// How it works
// - Base priority bits for six core sources
// - Extended priority one: timer3, SPI, ext2/3, hold
// - Extended priority two: first I2C, USB, PWM A
// - Extended priority three: second I2C, PWM C, B
// - Reserved bits read zero, writes ignored
// - Overflow flags set by hardware, cleared on vector
// - Run bits let timers count
// - Ext 0/1 flags set on event, cleared on vector
// - Type bit: zero low level, one edge
// - Ext 0/1 edge select: falling or rising
// - Ext 2/3 inputs active only when enabled
// - Ext 2/3 edge select: falling or rising
// - Deglitch filter 50, 200, 400 ns or bypass
// - Ext 2/3 flags set on edge, software clears
// - Any external pin event raises wake
// - Per port pin change enable bits
// - Pin change flags set by hardware, software clears
// - Any pin of enabled port sets its flag
// - Global enable gates every request
// - Flag still set after return re-requests
package ipx_pkg;
	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_TCTL  = 8'h88;
	localparam logic [7:0] ADDR_PCHG  = 8'hae;
	localparam logic [7:0] ADDR_X23F  = 8'haf;
	localparam logic [7:0] ADDR_XEN   = 8'hb5;
	localparam logic [7:0] ADDR_EDG1  = 8'hb6;
	localparam logic [7:0] ADDR_EDG2  = 8'hb7;
	localparam logic [7:0] ADDR_PRI0  = 8'hb8;
	localparam logic [7:0] ADDR_PRI1  = 8'hb9;
	localparam logic [7:0] ADDR_PRI2  = 8'hba;
	localparam logic [7:0] ADDR_PRI3  = 8'hbb;
	localparam logic [7:0] REG_RESET  = 8'h00;
	// ------------------------------------------------------------
	// Writable bit masks, reserved bits excluded
	// ------------------------------------------------------------
	localparam logic [7:0] MASK_TCTL  = 8'hff;
	localparam logic [7:0] MASK_PCHG  = 8'hbb;
	localparam logic [7:0] MASK_X23F  = 8'h03;
	localparam logic [7:0] MASK_XEN   = 8'h03;
	localparam logic [7:0] MASK_EDG1  = 8'hc5;
	localparam logic [7:0] MASK_EDG2  = 8'h03;
	localparam logic [7:0] MASK_PRI0  = 8'h5f;
	localparam logic [7:0] MASK_PRI1  = 8'h9a;
	localparam logic [7:0] MASK_PRI2  = 8'h25;
	localparam logic [7:0] MASK_PRI3  = 8'h23;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int TC_ZERO_TYPE = 0;
	localparam int TC_ZERO_FLAG = 1;
	localparam int TC_ONE_TYPE  = 2;
	localparam int TC_ONE_FLAG  = 3;
	localparam int TC_ZERO_RUN  = 4;
	localparam int TC_ZERO_OVF  = 5;
	localparam int TC_ONE_RUN   = 6;
	localparam int TC_ONE_OVF   = 7;
	localparam int ED_ZERO_SEL  = 0;
	localparam int ED_ONE_SEL   = 2;
	localparam int ED_DG_LO     = 6;
	localparam int PC_FLAG5     = 0;
	localparam int PC_FLAG6     = 1;
	localparam int PC_FLAG9     = 3;
	localparam int PC_EN5       = 4;
	localparam int PC_EN6       = 5;
	localparam int PC_EN9       = 7;
	// ------------------------------------------------------------
	// Source indices, lowest index wins within a level
	// ------------------------------------------------------------
	localparam int NSRC      = 16;
	localparam logic [3:0] SRC_EXT0 = 4'h0;
	localparam logic [3:0] SRC_TMR0 = 4'h1;
	localparam logic [3:0] SRC_EXT1 = 4'h2;
	localparam logic [3:0] SRC_TMR1 = 4'h3;
	// ------------------------------------------------------------
	// Deglitch timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ   = 200;
	localparam int DG0_NS    = 50;
	localparam int DG1_NS    = 200;
	localparam int DG2_NS    = 400;
	localparam int DG0_CYC   = (DG0_NS * CLK_MHZ + 999) / 1000;
	localparam int DG1_CYC   = (DG1_NS * CLK_MHZ + 999) / 1000;
	localparam int DG2_CYC   = (DG2_NS * CLK_MHZ + 999) / 1000;
	localparam logic [1:0] DG_BYPASS = 2'b11;

	typedef enum logic [1:0] {
		SVC_IDLE = 2'b00,
		SVC_LOW  = 2'b01,
		SVC_BOTH = 2'b11,
		SVC_HIGH = 2'b10
	} ipx_svc_e;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic [7:0] wdata;
	} ipx_sfr_s;

	typedef struct packed {
		logic       req;
		logic [3:0] src;
		logic       high;
	} ipx_req_s;
endpackage

// ### sim/ipx_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ipx_core_asserts
	import ipx_pkg::*;
(
	input wire logic              core_clk_in,
	input wire logic              nrst_in,
	input wire ipx_pkg::ipx_sfr_s sfr_in,
	input wire logic [7:0]        sfr_rdata_out,
	input wire logic              tmr0_ovf_in,
	input wire logic              global_irq_enable_in,
	input wire logic              irq_ack_in,
	input wire logic              reti_in,
	input wire ipx_pkg::ipx_req_s irq_out,
	input wire logic              timer_zero_run_out,
	input wire logic              timer_one_run_out
);
	logic [7:0] wd1_q;
	logic [7:0] wd2_q;

	// Write data two cycles back, so readback checks need no $past on a slice
	always_ff @(posedge core_clk_in) begin
		wd1_q <= sfr_in.wdata;
		wd2_q <= wd1_q;
	end

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);

	// Plain read with no vectoring, so no flag is cleared under it
	sequence s_rd(a);
		!sfr_in.wr && sfr_in.addr == a && !irq_ack_in;
	endsequence
	sequence s_wr_ctl;
		sfr_in.wr && sfr_in.addr == ADDR_TCTL;
	endsequence
	sequence s_low_taken;
		irq_ack_in && irq_out.req && !irq_out.high;
	endsequence
	sequence s_high_taken;
		irq_ack_in && irq_out.req && irq_out.high;
	endsequence

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	a_prio_write_read: assert property (
		sfr_in.wr && sfr_in.addr == ADDR_PRI0 ##1 s_rd(ADDR_PRI0)
		|=> sfr_rdata_out == (wd2_q & MASK_PRI0)) else $error("priority readback wrong");
	a_prio_one_reserved: assert property (
		sfr_in.addr == ADDR_PRI1 |=> (sfr_rdata_out & ~MASK_PRI1) == 8'h00)
		else $error("reserved priority bit reads one");
	a_prio_three_reserved: assert property (
		sfr_in.addr == ADDR_PRI3 |=> (sfr_rdata_out & ~MASK_PRI3) == 8'h00)
		else $error("reserved priority bit reads one");
	a_unmapped_reads_zero: assert property (
		sfr_in.addr == 8'hb4 |=> sfr_rdata_out == 8'h00) else $error("unmapped read not zero");
	a_run_bits_follow: assert property (
		s_wr_ctl ##1 !(sfr_in.wr && sfr_in.addr == ADDR_TCTL)
		|=> {timer_one_run_out, timer_zero_run_out} == {wd2_q[TC_ONE_RUN], wd2_q[TC_ZERO_RUN]})
		else $error("run outputs do not follow control");
	a_ovf_sets_flag: assert property (
		tmr0_ovf_in ##1 (!sfr_in.wr && !irq_ack_in) ##1 s_rd(ADDR_TCTL) [*2]
		|-> sfr_rdata_out[TC_ZERO_OVF])
		else $error("overflow flag not set");

	// ----------------------------------------
	// Request arbitration
	// ----------------------------------------
	a_global_gate: assert property (
		!global_irq_enable_in [*3] |-> !irq_out.req) else $error("request with global enable off");
	a_high_ack_drops: assert property (
		s_high_taken |=> !irq_out.req) else $error("request stays after high vector");
	a_low_not_nested: assert property (
		s_low_taken ##1 !reti_in [*3] |-> !(irq_out.req && !irq_out.high))
		else $error("low request inside a routine");
	a_high_not_nested: assert property (
		s_high_taken ##1 !reti_in [*3] |-> !irq_out.req) else $error("request inside high routine");
endmodule
`default_nettype wire

// ### sim/ipx_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module ipx_pin_model (
	input  wire logic      clk_in,
	output var logic [3:0] ext_pins_out,
	output var logic [7:0] port5_out,
	output var logic [7:0] port6_out,
	output var logic [7:0] port9_out
);
	// Interrupt pins rest at their pull-up level; ports start low
	initial begin
		ext_pins_out = 4'hf;
		port5_out = 8'h00;
		port6_out = 8'h00;
		port9_out = 8'h00;
	end

	// Pin levels change only just after an edge
	task automatic set_pin(input int i, input logic v);
		@(posedge clk_in);
		ext_pins_out[i] <= v;
	endtask

	// Low pulse of n cycles, used to probe the glitch filter
	task automatic pulse_low(input int i, input int n);
		set_pin(i, 1'b0);
		repeat (n - 1) @(posedge clk_in);
		set_pin(i, 1'b1);
	endtask

	// Toggle one pin of port 0 = five, 1 = six, 2 = nine
	task automatic flip_port(input int k, input int b);
		@(posedge clk_in);
		case (k)
			0: port5_out[b] <= ~port5_out[b];
			1: port6_out[b] <= ~port6_out[b];
			default: port9_out[b] <= ~port9_out[b];
		endcase
	endtask
endmodule
`default_nettype wire

// ### sim/test_irq_priority_extint_pinchange.sv
`timescale 1ns/1ps
`default_nettype none
module test_irq_priority_extint_pinchange;
	import ipx_pkg::*;
	localparam int TC = 0, PC = 1, XF = 2, XE = 3, E1 = 4, E2 = 5, P0 = 6, P1 = 7, P2 = 8, P3 = 9;
	logic        clk;
	logic        nrst;
	ipx_sfr_s    sfr;
	logic [7:0]  rdata;
	logic [3:0]  pins;
	logic [7:0]  p5, p6, p9;
	logic        ovf0, ovf1, gie, ack, reti, run0, run1, wake;
	logic [15:0] src_en;
	logic [9:0]  pf;
	ipx_req_s    irq;
	int          n_fail = 0, n_tests = 0, n_wake = 0, seed = 78, w0, b, lim, h;
	// Peripheral flag bit to source index, priority register and priority bit
	int          pf_src[10] = '{4, 6, 6, 6, 8, 9, 10, 11, 12, 13};
	int          pf_reg[10] = '{P0, P1, P1, P1, P1, P1, P2, P2, P2, P3};
	int          pf_bit[10] = '{4, 1, 1, 1, 4, 7, 0, 2, 5, 0};
	logic [7:0]  mdl[11] = '{default: 8'h00};
	logic [7:0]  adr_t[11] = '{ADDR_TCTL, ADDR_PCHG, ADDR_X23F, ADDR_XEN, ADDR_EDG1, ADDR_EDG2,
		ADDR_PRI0, ADDR_PRI1, ADDR_PRI2, ADDR_PRI3, 8'hb4};
	logic [7:0]  msk_t[11] = '{MASK_TCTL, MASK_PCHG, MASK_X23F, MASK_XEN, MASK_EDG1, MASK_EDG2,
		MASK_PRI0, MASK_PRI1, MASK_PRI2, MASK_PRI3, 8'h00};

	ipx_core dut (
		.core_clk_in          (clk),
		.nrst_in              (nrst),
		.sfr_in               (sfr),
		.sfr_rdata_out        (rdata),
		.ext_pins_in          (pins),
		.port5_in             (p5),
		.port6_in             (p6),
		.port9_in             (p9),
		.tmr0_ovf_in          (ovf0),
		.tmr1_ovf_in          (ovf1),
		.periph_flags_in      (pf),
		.src_enable_in        (src_en),
		.global_irq_enable_in (gie),
		.irq_ack_in           (ack),
		.reti_in              (reti),
		.irq_out              (irq),
		.timer_zero_run_out   (run0),
		.timer_one_run_out    (run1),
		.wake_out             (wake)
	);
	ipx_pin_model pins_m (
		.clk_in       (clk),
		.ext_pins_out (pins),
		.port5_out    (p5),
		.port6_out    (p6),
		.port9_out    (p9)
	);

	// 200 MHz clock; wake pulses are counted for the event checks
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) if (wake === 1'b1) n_wake++;

	// ----------------------------------------
	// Compare, bus and strobe tasks
	// ----------------------------------------
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected data at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_irq(input ipx_req_s e);
		#1 n_tests++;
		if (e.req ? irq !== e : irq.req !== 1'b0) begin
			n_fail++;
			$display("unexpected request at %0t: got %h want %h", $time, irq, e);
		end
	endtask
	// Writes update the model with the writable bits only
	task automatic wr(input int i, input logic [7:0] d);
		@(posedge clk);
		sfr <= '{adr_t[i], 1'b1, d};
		@(posedge clk);
		sfr.wr <= 1'b0;
		mdl[i] = d & msk_t[i];
	endtask
	task automatic rd(input int i);
		@(posedge clk);
		sfr <= '{adr_t[i], 1'b0, 8'h00};
		repeat (2) @(posedge clk);
		#1 chk_reg(rdata, mdl[i]);
	endtask
	// One-cycle pulse: 0 vector taken, 1 return, 2 and 3 timer overflows
	task automatic strobe(input int w);
		@(posedge clk);
		{ovf1, ovf0, reti, ack} <= 4'(1 << w);
		@(posedge clk);
		{ovf1, ovf0, reti, ack} <= 4'h0;
	endtask
	// Bounded wait so a missing request cannot hang the run
	task automatic wait_req(input ipx_req_s e);
		for (int n = 0; n < 20 && irq.req !== 1'b1; n++) @(posedge clk);
		chk_irq(e);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		test_done;
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{nrst, ovf1, ovf0, reti, ack, gie} = '0;
		sfr = '0;
		src_en = 16'h0000;
		pf = 10'h000;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 11; i++) rd(i);
		for (int i = 0; i < 11; i++) begin
			for (int r = 0; r < 4; r++) begin
				wr(i, 8'($random(seed)));
				rd(i);
				if (i == TC) chk_reg({6'h00, run1, run0}, {6'h00, mdl[TC][6], mdl[TC][4]});
			end
			wr(i, 8'h00);
		end
		for (int t = 0; t < 2; t++) begin
			strobe(2 + t);
			mdl[TC][t ? TC_ONE_OVF : TC_ZERO_OVF] = 1'b1;
			rd(TC);
		end
		wr(TC, 8'h00);
		rd(TC);
		// Upper pins: enable, edge choice, set only by the chosen edge
		wr(E1, 8'hc0);
		for (int p = 2; p < 4; p++)
			for (int en = 0; en < 2; en++)
				for (int s = 0; s < 2; s++) begin
					wr(XE, 8'(en << (p - 2)));
					wr(E2, 8'(s << (p - 2)));
					wr(XF, 8'h00);
					w0 = n_wake;
					pins_m.set_pin(p, 1'b0);
					repeat (6) @(posedge clk);
					if (en && !s) mdl[XF][p - 2] = 1'b1;
					rd(XF);
					pins_m.set_pin(p, 1'b1);
					repeat (6) @(posedge clk);
					if (en) mdl[XF][p - 2] = 1'b1;
					rd(XF);
					chk_reg(8'(n_wake > w0), 8'(en));
				end
		// Glitch filter: a pulse just short of the span is lost, just over is kept
		wr(XE, 8'h01);
		wr(E2, 8'h00);
		for (int c = 0; c < 3; c++) begin
			lim = c == 0 ? DG0_CYC : c == 1 ? DG1_CYC : DG2_CYC;
			wr(E1, 8'(c << 6));
			wr(XF, 8'h00);
			pins_m.pulse_low(2, lim - 4);
			repeat (lim + 8) @(posedge clk);
			rd(XF);
			pins_m.pulse_low(2, lim + 4);
			repeat (lim + 8) @(posedge clk);
			mdl[XF][0] = 1'b1;
			rd(XF);
		end
		// Lower pins in level mode and in both edge modes
		for (int p = 0; p < 2; p++)
			for (int t = 0; t < 2; t++)
				for (int s = 0; s < 2; s++) begin
					wr(E1, 8'hc0 | 8'(s << (2 * p)));
					wr(TC, 8'(t << (2 * p)));
					pins_m.set_pin(p, 1'b0);
					repeat (6) @(posedge clk);
					if (!t || !s) mdl[TC][2 * p + 1] = 1'b1;
					rd(TC);
					pins_m.set_pin(p, 1'b1);
					repeat (6) @(posedge clk);
					mdl[TC][2 * p + 1] = 1'b1;
					rd(TC);
				end
		// Pin change on a random pin, port enabled or not
		for (int k = 0; k < 3; k++)
			for (int en = 0; en < 2; en++) begin
				lim = k == 2 ? 7 : k + 4;
				wr(PC, 8'(en << lim));
				b = $unsigned($random(seed)) % 8;
				pins_m.flip_port(k, b);
				repeat (4) @(posedge clk);
				if (en) mdl[PC][lim - 4] = 1'b1;
				rd(PC);
				wr(PC, 8'h00);
				rd(PC);
			end
		// Gating, vectoring, nesting and re-request after return
		@(posedge clk) src_en <= 16'h0003;
		wr(TC, 8'h20);
		repeat (8) @(posedge clk);
		chk_irq('0);
		@(posedge clk) gie <= 1'b1;
		wait_req('{1'b1, SRC_TMR0, 1'b0});
		strobe(0);
		mdl[TC] = 8'h00;
		rd(TC);
		wr(P0, 8'h01);
		wr(TC, 8'h03);
		wait_req('{1'b1, SRC_EXT0, 1'b1});
		strobe(0);
		mdl[TC] = 8'h01;
		rd(TC);
		wr(TC, 8'h21);
		repeat (8) @(posedge clk);
		chk_irq('0);
		strobe(1);
		repeat (8) @(posedge clk);
		chk_irq('0);
		strobe(1);
		wait_req('{1'b1, SRC_TMR0, 1'b0});
		strobe(0);
		strobe(1);
		// Peripheral flags: each source requests at the level of its priority bit
		@(posedge clk) src_en <= 16'hff70;
		for (int j = 0; j < 10; j++) begin
			h = $unsigned($random(seed)) % 2;
			wr(pf_reg[j], 8'(h << pf_bit[j]));
			@(posedge clk) pf <= 10'(1 << j);
			wait_req('{1'b1, 4'(pf_src[j]), 1'(h)});
			strobe(0);
			@(posedge clk) pf <= 10'h000;
			strobe(1);
		end
		test_done;
	end
endmodule

bind ipx_core ipx_core_asserts u_chk (
	.core_clk_in          (core_clk_in),
	.nrst_in              (nrst_in),
	.sfr_in               (sfr_in),
	.sfr_rdata_out        (sfr_rdata_out),
	.tmr0_ovf_in          (tmr0_ovf_in),
	.global_irq_enable_in (global_irq_enable_in),
	.irq_ack_in           (irq_ack_in),
	.reti_in              (reti_in),
	.irq_out              (irq_out),
	.timer_zero_run_out   (timer_zero_run_out),
	.timer_one_run_out    (timer_one_run_out)
);
`default_nettype wire
